// [hdl/ssm_analyzer_tail.sv]
`include "ssm_params.svh"

// Overview of operation
// - selected frames copied to sampling cpu queue
// - separately programmable per-port sampling probability
// - independent rx and tx candidate enables
// - learn frames mirrored when learn mirroring active
// - cpu mirror when cpu port in destinations
// - ingress port mirror enable marks frame
// - egress mirror mask hits destination set
// - flag_a flag marks frame
// - rule engine mirror request marks frame
// - mirrored frames gain mirror destination ports
// - cpu mirror destination adds mirror cpu queue
// - learn frames with learn_ena gain learn mirror ports
// - cpu self kill removes cpu port last
// - station move sets new port bit
// - analyzer events kept as sticky flags
// - count learn discards from full table
module ssm_analyzer_tail (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                frm_valid,
  input  wire ssm_pkg::ssm_idx_t   frm_src_port,
  input  wire ssm_pkg::ssm_mask_t  frm_destination_set,
  input  wire ssm_pkg::ssm_cpu_queue_mask_t  frm_cpu_queue_mask,
  input  wire logic                frm_learn,
  input  wire logic                frm_learn_ena,
  input  wire logic                frm_flag_a,
  input  wire logic                frm_rule_hit,
  input  wire logic                frm_rule_mirror_request,
  output logic                     out_valid,
  output ssm_pkg::ssm_mask_t       out_destination_set,
  output ssm_pkg::ssm_cpu_queue_mask_t       out_cpu_queue_mask,
  output logic                     out_sampled,
  output logic                     out_mirrored,
  input  wire logic                move_valid,
  input  wire ssm_pkg::ssm_idx_t   move_destination_index,
  input  wire ssm_pkg::ssm_evt_t   event_pulse,
  input  wire logic                learn_discard_pulse,
  output logic                     irq
);

  ssm_samp_if                sif ();
  ssm_pkg::ssm_smp_cfg_t     smp_cfg_reg [`SSM_NPORT];
  ssm_pkg::ssm_qnum_t        smp_q_reg;
  ssm_pkg::ssm_qnum_t        mir_q_reg;
  logic                      cpu_mirror_reg;
  logic                      self_kill_reg;
  ssm_pkg::ssm_mask_t        ingr_mir_reg;
  ssm_pkg::ssm_mask_t        egr_mir_reg;
  ssm_pkg::ssm_mask_t        mir_destination_set_reg;
  ssm_pkg::ssm_mask_t        learn_mir_reg;
  ssm_pkg::ssm_stat_t        status_reg;
  ssm_pkg::ssm_stat_t        status_next;
  ssm_pkg::ssm_stat_t        irq_en_reg;
  ssm_pkg::ssm_stat_t        clr_mask;
  ssm_pkg::ssm_stat_t        set_mask;
  logic [31:0]               disc_cnt_reg;
  logic [31:0]               prdata_reg;
  logic [31:0]               rd_data;
  logic                      addr_ok;
  logic                      wr_en;
  logic                      out_valid_reg;
  ssm_pkg::ssm_mask_t        out_destination_set_reg;
  ssm_pkg::ssm_cpu_queue_mask_t        out_cpu_queue_mask_reg;
  logic                      out_sampled_reg;
  logic                      out_mirrored_reg;
  ssm_pkg::ssm_mask_t        destination_set_next;
  ssm_pkg::ssm_cpu_queue_mask_t        cpu_queue_mask_next;
  logic                      mirror_hit;
  logic                      src_is_cpu;

  localparam ssm_pkg::ssm_mask_t CPU_BIT = ssm_pkg::ssm_mask_t'(1) << `SSM_CPU_PORT;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave

  // zero wait states; writes land on the access edge
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_reg;

  // read decode; unmapped or misaligned addresses flag an error
  always_comb
  begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr[1:0] != 2'b00)
      addr_ok = 1'b0;
    else if (paddr[7:5] == 3'h0)
    begin
      if (paddr[4:2] < 3'(`SSM_NPORT))
        rd_data = 32'(smp_cfg_reg[paddr[4:2]]);
      else
        addr_ok = 1'b0;
    end
    else
    begin
      case (paddr)
        `SSM_OFF_QUEUE_CFG:
          rd_data = 32'({1'b0, mir_q_reg, 1'b0, smp_q_reg});
        `SSM_OFF_GEN_CTRL:
          rd_data = 32'({self_kill_reg, cpu_mirror_reg});
        `SSM_OFF_INGR_MIR:   rd_data = 32'(ingr_mir_reg);
        `SSM_OFF_EGR_MIR:    rd_data = 32'(egr_mir_reg);
        `SSM_OFF_MIR_DESTINATION_SET:   rd_data = 32'(mir_destination_set_reg);
        `SSM_OFF_ADV_LEARN:  rd_data = 32'(learn_mir_reg);
        `SSM_OFF_MOVE_MASK:  rd_data = 32'(status_reg[`SSM_NPORT-1:0]);
        `SSM_OFF_IRQ_STATUS: rd_data = 32'(status_reg);
        `SSM_OFF_IRQ_CLEAR:  rd_data = 32'h0000_0000;  // write-only
        `SSM_OFF_IRQ_ENABLE: rd_data = 32'(irq_en_reg);
        `SSM_OFF_LEARN_DISC: rd_data = disc_cnt_reg;
        default:             addr_ok = 1'b0;
      endcase
    end
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_reg <= rd_data;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // per-port sampling agent configuration
  for (genvar p = 0; p < `SSM_NPORT; p++)
  begin : g_port
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        smp_cfg_reg[p] <= `SSM_RST_SAMPLE_CFG;
      else if (wr_en && paddr == 8'(`SSM_OFF_SAMPLE_CFG0 + `SSM_SAMPLE_STRIDE * p))
        smp_cfg_reg[p] <= pwdata[`SSM_SMP_TX_BIT:0];
    end
    assign sif.rate[p]  = smp_cfg_reg[p][`SSM_SMP_RATE_LSB +: `SSM_RATE_W];
    assign sif.rx_en[p] = smp_cfg_reg[p][`SSM_SMP_RX_BIT];
    assign sif.tx_en[p] = smp_cfg_reg[p][`SSM_SMP_TX_BIT];
  end

  // global mirroring and queue settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp_q_reg      <= `SSM_RST_QUEUE_CFG;
      mir_q_reg      <= `SSM_RST_QUEUE_CFG;
      cpu_mirror_reg <= 1'b0;
      self_kill_reg  <= 1'b0;
      ingr_mir_reg   <= `SSM_RST_MASK;
      egr_mir_reg    <= `SSM_RST_MASK;
      mir_destination_set_reg   <= `SSM_RST_MASK;
      learn_mir_reg  <= `SSM_RST_MASK;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SSM_OFF_QUEUE_CFG:
        begin
          smp_q_reg <= pwdata[`SSM_QC_SAMPLE_LSB +: 3];
          mir_q_reg <= pwdata[`SSM_QC_MIRROR_LSB +: 3];
        end
        `SSM_OFF_GEN_CTRL:
        begin
          cpu_mirror_reg <= pwdata[`SSM_GC_CPU_MIR_BIT];
          self_kill_reg  <= pwdata[`SSM_GC_KILL_BIT];
        end
        `SSM_OFF_INGR_MIR:  ingr_mir_reg  <= pwdata[`SSM_NPORT-1:0];
        `SSM_OFF_EGR_MIR:   egr_mir_reg   <= pwdata[`SSM_NPORT-1:0];
        `SSM_OFF_MIR_DESTINATION_SET:  mir_destination_set_reg  <= pwdata[`SSM_NPORT-1:0];
        `SSM_OFF_ADV_LEARN: learn_mir_reg <= pwdata[`SSM_NPORT-1:0];
        default:            ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sampler

  assign sif.req  = frm_valid;
  assign sif.src  = frm_src_port;
  assign sif.destination_set = frm_destination_set;

  ssm_sampler u_sampler (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // forwarding adjustment: sampling, mirroring, self kill

  assign src_is_cpu = (frm_src_port == 3'(`SSM_CPU_PORT));

  // steps applied in order; self kill comes last
  always_comb
  begin
    destination_set_next = frm_destination_set;
    cpu_queue_mask_next = frm_cpu_queue_mask;
    if (sif.hit)
    begin
      destination_set_next            = destination_set_next | CPU_BIT;
      cpu_queue_mask_next[smp_q_reg] = 1'b1;
    end
    mirror_hit = (frm_learn && learn_mir_reg != '0)
               || (cpu_mirror_reg && destination_set_next[`SSM_CPU_PORT])
               || ingr_mir_reg[frm_src_port]
               || ((egr_mir_reg & destination_set_next) != '0)
               || frm_flag_a
               || (frm_rule_hit && frm_rule_mirror_request);
    if (mirror_hit)
    begin
      destination_set_next = destination_set_next | mir_destination_set_reg;
      if (mir_destination_set_reg[`SSM_CPU_PORT])
        cpu_queue_mask_next[mir_q_reg] = 1'b1;
    end
    if (frm_learn && frm_learn_ena)
      destination_set_next = destination_set_next | learn_mir_reg;
    if (self_kill_reg && src_is_cpu)
      destination_set_next = destination_set_next & ~CPU_BIT;
  end

  // one-cycle result stage toward the queue system
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid_reg    <= 1'b0;
      out_destination_set_reg     <= `SSM_RST_MASK;
      out_cpu_queue_mask_reg     <= '0;
      out_sampled_reg  <= 1'b0;
      out_mirrored_reg <= 1'b0;
    end
    else
    begin
      out_valid_reg <= frm_valid;
      if (frm_valid)
      begin
        out_destination_set_reg     <= destination_set_next;
        out_cpu_queue_mask_reg     <= cpu_queue_mask_next;
        out_sampled_reg  <= sif.hit;
        out_mirrored_reg <= mirror_hit;
      end
    end
  end

  assign out_valid           = out_valid_reg;
  assign out_destination_set = out_destination_set_reg;
  assign out_cpu_queue_mask  = out_cpu_queue_mask_reg;
  assign out_sampled         = out_sampled_reg;
  assign out_mirrored        = out_mirrored_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // monitoring: station moves, sticky events, discard counter, interrupt

  // set sources; out-of-range move index shifts out to nothing
  assign set_mask = {event_pulse,
                     ssm_pkg::ssm_mask_t'(1) << move_destination_index & {5{move_valid}}};
  assign clr_mask = (wr_en && paddr == `SSM_OFF_IRQ_CLEAR)
                    ? pwdata[`SSM_NPORT+`SSM_NEVT-1:0] : '0;
  // a set in the clear cycle wins
  assign status_next = (status_reg & ~clr_mask) | set_mask;

  // sticky status, write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= `SSM_RST_STATUS;
    else
      status_reg <= status_next;
  end

  // interrupt enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en_reg <= `SSM_RST_STATUS;
    else if (wr_en && paddr == `SSM_OFF_IRQ_ENABLE)
      irq_en_reg <= pwdata[`SSM_NPORT+`SSM_NEVT-1:0];
  end

  assign irq = |(status_reg & irq_en_reg);

  // discard counter, wraps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disc_cnt_reg <= `SSM_RST_COUNT;
    else if (learn_discard_pulse)
      disc_cnt_reg <= disc_cnt_reg + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sample_copy;
    frm_valid && sif.hit |=> out_sampled && out_cpu_queue_mask[$past(smp_q_reg)];
  endproperty
  a_sample_copy: assert property (p_sample_copy) else $error("sample not queued");

  property p_no_candidate;
    frm_valid && !sif.rx_en[frm_src_port] && ((sif.tx_en & frm_destination_set) == '0)
      |=> !out_sampled;
  endproperty
  a_no_candidate: assert property (p_no_candidate) else $error("non-candidate sampled");

  property p_cpu_mirror;
    frm_valid && cpu_mirror_reg && frm_destination_set[`SSM_CPU_PORT] |=> out_mirrored;
  endproperty
  a_cpu_mirror: assert property (p_cpu_mirror) else $error("cpu mirror missed");

  property p_ingr_mirror;
    frm_valid && ingr_mir_reg[frm_src_port] |=> out_valid && out_mirrored;
  endproperty
  a_ingr_mirror: assert property (p_ingr_mirror) else $error("ingress mirror missed");

  property p_egr_mirror;
    frm_valid && ((egr_mir_reg & frm_destination_set) != '0) |=> out_mirrored;
  endproperty
  a_egr_mirror: assert property (p_egr_mirror) else $error("egress mirror missed");

  property p_mirror_ports;
    frm_valid && mirror_hit |=>
      ((out_destination_set | CPU_BIT) & $past(mir_destination_set_reg)) == $past(mir_destination_set_reg);
  endproperty
  a_mirror_ports: assert property (p_mirror_ports) else $error("mirror ports missing");

  property p_self_kill;
    frm_valid && self_kill_reg && src_is_cpu |=> !out_destination_set[`SSM_CPU_PORT];
  endproperty
  a_self_kill: assert property (p_self_kill) else $error("cpu port not removed");

  // bit set next cycle and still held a cycle later unless a clear came in between
  property p_station_move;
    move_valid && move_destination_index < 3'(`SSM_NPORT)
      |=> status_reg[$past(move_destination_index)]
          ##1 (status_reg[$past(move_destination_index, 2)] || $past(clr_mask) != '0);
  endproperty
  a_station_move: assert property (p_station_move) else $error("move bit not held");

  property p_discard_count;
    learn_discard_pulse |=> disc_cnt_reg == $past(disc_cnt_reg) + 32'h0000_0001;
  endproperty
  a_discard_count: assert property (p_discard_count) else $error("discard miscount");

  property p_sticky_hold;
    ($past(status_reg & ~clr_mask) & ~status_reg) == '0;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit lost");

  property p_irq_level;
    ((status_reg & irq_en_reg) != '0) == irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  c_mirrored:  cover property (frm_valid && mirror_hit ##1 out_mirrored);
  c_sampled:   cover property (frm_valid && sif.hit ##1 out_sampled);
  c_self_kill: cover property (frm_valid && self_kill_reg && src_is_cpu);
  c_irq:       cover property (!irq ##1 irq);

endmodule

// [hdl/ssm_params.svh]
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

// port counts and widths
`define SSM_NPORT          5
`define SSM_CPU_PORT       4
`define SSM_NEVT           4
`define SSM_RATE_W         12
`define SSM_NQUEUE         8
`define SSM_LFSR_SEED      16'hACE1

// register byte offsets
`define SSM_OFF_SAMPLE_CFG0 8'h00
`define SSM_SAMPLE_STRIDE   4
`define SSM_OFF_QUEUE_CFG   8'h20
`define SSM_OFF_GEN_CTRL    8'h24
`define SSM_OFF_INGR_MIR    8'h28
`define SSM_OFF_EGR_MIR     8'h2C
`define SSM_OFF_MIR_DESTINATION_SET    8'h30
`define SSM_OFF_ADV_LEARN   8'h34
`define SSM_OFF_MOVE_MASK   8'h40
`define SSM_OFF_IRQ_STATUS  8'h44
`define SSM_OFF_IRQ_CLEAR   8'h48
`define SSM_OFF_IRQ_ENABLE  8'h4C
`define SSM_OFF_LEARN_DISC  8'h50

// field positions
`define SSM_SMP_RATE_LSB   0
`define SSM_SMP_RX_BIT     12
`define SSM_SMP_TX_BIT     13
`define SSM_QC_SAMPLE_LSB  0
`define SSM_QC_MIRROR_LSB  4
`define SSM_GC_CPU_MIR_BIT 0
`define SSM_GC_KILL_BIT    1
`define SSM_ST_EVT_LSB     5

// reset values
`define SSM_RST_SAMPLE_CFG 14'h0000
`define SSM_RST_QUEUE_CFG  3'h0
`define SSM_RST_MASK       5'h00
`define SSM_RST_STATUS     9'h000
`define SSM_RST_COUNT      32'h0000_0000

`endif

// [hdl/ssm_pkg.sv]
`include "ssm_params.svh"

package ssm_pkg;

  // one bit per port, cpu port included
  typedef logic [`SSM_NPORT-1:0]            ssm_mask_t;
  typedef logic [2:0]                       ssm_idx_t;
  typedef logic [`SSM_NQUEUE-1:0]           ssm_cpu_queue_mask_t;
  typedef logic [2:0]                       ssm_qnum_t;
  typedef logic [`SSM_RATE_W-1:0]           ssm_rate_t;
  typedef logic [`SSM_SMP_TX_BIT:0]         ssm_smp_cfg_t;
  typedef logic [`SSM_NEVT-1:0]             ssm_evt_t;
  typedef logic [`SSM_NPORT+`SSM_NEVT-1:0]  ssm_stat_t;

endpackage

// [hdl/ssm_samp_if.sv]
`include "ssm_params.svh"

// sampler configuration and per-frame request
interface ssm_samp_if;
  ssm_pkg::ssm_rate_t  rate [`SSM_NPORT];
  ssm_pkg::ssm_mask_t  rx_en;
  ssm_pkg::ssm_mask_t  tx_en;
  logic                req;
  ssm_pkg::ssm_idx_t   src;
  ssm_pkg::ssm_mask_t  destination_set;
  logic                hit;

  modport ctl (output rate, rx_en, tx_en, req, src, destination_set, input hit);
  modport smp (input rate, rx_en, tx_en, req, src, destination_set, output hit);
endinterface

// [hdl/ssm_sampler.sv]
`include "ssm_params.svh"

module ssm_sampler (
  input  wire logic  pclk,
  input  wire logic  presetn,
  ssm_samp_if.smp    sif
);

  logic [15:0]         lfsr_reg;
  ssm_pkg::ssm_mask_t  sel;

  // free-running generator, advances every cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr_reg <= `SSM_LFSR_SEED;
    else
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end

  // per-port candidate and draw; each port looks at a rotated slice
  for (genvar p = 0; p < `SSM_NPORT; p++)
  begin : g_draw
    logic [15:0]         rot;
    ssm_pkg::ssm_rate_t  draw;
    logic                cand;
    assign rot  = (lfsr_reg << (3 * p)) | (lfsr_reg >> (16 - 3 * p));
    assign draw = rot[`SSM_RATE_W-1:0];
    assign cand = sif.req && ((sif.rx_en[p] && (sif.src == 3'(p)))
                  || (sif.tx_en[p] && sif.destination_set[p]));
    assign sel[p] = cand && (draw < sif.rate[p]);
  end

  assign sif.hit = |sel;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // the first edge after release still sees the seed held during reset
  property p_lfsr_moves;
    $past(presetn) |-> lfsr_reg != $past(lfsr_reg);
  endproperty
  a_lfsr_moves: assert property (p_lfsr_moves) else $error("lfsr stuck");

  property p_hit_needs_req;
    sif.hit |-> sif.req && ((sif.rx_en & (5'h01 << sif.src)) != '0
                || (sif.tx_en & sif.destination_set) != '0);
  endproperty
  a_hit_needs_req: assert property (p_hit_needs_req) else $error("hit without candidate");

endmodule

// [verification/ssm_stage_model.sv]
`include "ssm_params.svh"

// earlier analyzer stages hand over one frame decision, the queue side collects the answer
module ssm_stage_model (
  input  wire logic                pclk,
  output logic                     frm_valid,
  output ssm_pkg::ssm_idx_t        frm_src_port,
  output ssm_pkg::ssm_mask_t       frm_destination_set,
  output ssm_pkg::ssm_cpu_queue_mask_t       frm_cpu_queue_mask,
  output logic                     frm_learn,
  output logic                     frm_learn_ena,
  output logic                     frm_flag_a,
  output logic                     frm_rule_hit,
  output logic                     frm_rule_mirror_request,
  input  wire logic                out_valid,
  input  wire ssm_pkg::ssm_mask_t  out_destination_set,
  input  wire ssm_pkg::ssm_cpu_queue_mask_t  out_cpu_queue_mask,
  input  wire logic                out_sampled,
  input  wire logic                out_mirrored
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pipeline at time zero
  initial
  begin
    frm_valid = 1'b0;
    frm_src_port = '0;
    frm_destination_set = '0;
    frm_cpu_queue_mask = '0;
    {frm_learn, frm_learn_ena, frm_flag_a, frm_rule_hit, frm_rule_mirror_request} = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-cycle frame, then the released fields flip so stale values cannot pass
  task automatic send(input ssm_pkg::ssm_idx_t s, input ssm_pkg::ssm_mask_t d,
                      input ssm_pkg::ssm_cpu_queue_mask_t q, input logic [4:0] f,
                      output ssm_pkg::ssm_mask_t od, output ssm_pkg::ssm_cpu_queue_mask_t oq,
                      output logic os, output logic om, output logic ok);
    int n;
    @(posedge pclk);
    frm_valid <= 1'b1;
    frm_src_port <= s;
    frm_destination_set <= d;
    frm_cpu_queue_mask <= q;
    {frm_learn, frm_learn_ena, frm_flag_a, frm_rule_hit, frm_rule_mirror_request} <= f;
    @(posedge pclk);
    frm_valid <= 1'b0;
    frm_src_port <= ~s;
    frm_destination_set <= ~d;
    frm_cpu_queue_mask <= ~q;
    {frm_learn, frm_learn_ena, frm_flag_a, frm_rule_hit, frm_rule_mirror_request} <= ~f;
    n = 0;
    ok = 1'b0;
    while (n < 4 && !ok)
    begin
      @(negedge pclk);
      ok = (out_valid === 1'b1);
      n++;
    end
    od = out_destination_set;
    oq = out_cpu_queue_mask;
    os = out_sampled;
    om = out_mirrored;
  endtask
endmodule

// [verification/ssm_analyzer_tail_tb.sv]
`include "ssm_params.svh"

module ssm_analyzer_tail_tb;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(a, b) \
    begin \
      comparisons++; \
      if ((a) !== (b)) \
      begin \
        err_count++; \
        $display("Error at %0t ns: got %0h expected %0h", $time, (a), (b)); \
      end \
    end

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rdata;
  logic                frm_valid, frm_learn, frm_learn_ena, frm_flag_a, frm_rule_hit;
  logic                frm_rule_mirror_request, out_valid, out_sampled, out_mirrored;
  logic                move_valid, learn_discard_pulse, os, om, ok;
  ssm_pkg::ssm_idx_t   frm_src_port, move_destination_index;
  ssm_pkg::ssm_mask_t  frm_destination_set, out_destination_set, od;
  ssm_pkg::ssm_cpu_queue_mask_t  frm_cpu_queue_mask, out_cpu_queue_mask, oq;
  ssm_pkg::ssm_evt_t   event_pulse;
  int                  err_count, comparisons, nsmp;
  logic [7:0]          ra [6] = '{8'h00, 8'h20, 8'h24, 8'h2C, 8'h44, 8'h50};
  logic [31:0]         scfg [4] = '{32'h1000, 32'h1FFF, 32'h2FFF, 32'h2FFF};
  ssm_pkg::ssm_idx_t   ssrc [4] = '{3'h0, 3'h0, 3'h0, 3'h1};
  ssm_pkg::ssm_mask_t  sdst [4] = '{5'h01, 5'h01, 5'h02, 5'h01};
  logic                sany [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  ssm_analyzer_tail u_ssm_analyzer_tail (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .frm_valid, .frm_src_port, .frm_destination_set,
    .frm_cpu_queue_mask, .frm_learn, .frm_learn_ena, .frm_flag_a, .frm_rule_hit,
    .frm_rule_mirror_request, .out_valid, .out_destination_set, .out_cpu_queue_mask,
    .out_sampled, .out_mirrored, .move_valid, .move_destination_index, .event_pulse,
    .learn_discard_pulse, .irq);

  ssm_stage_model u_ssm_stage_model (.pclk, .frm_valid, .frm_src_port, .frm_destination_set,
    .frm_cpu_queue_mask, .frm_learn, .frm_learn_ena, .frm_flag_a, .frm_rule_hit,
    .frm_rule_mirror_request, .out_valid, .out_destination_set, .out_cpu_queue_mask,
    .out_sampled, .out_mirrored);

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdata, e)
  endtask

  // irq is checked away from the edge so register updates have landed
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    `CHK(irq, e)
  endtask

  task automatic frm(input ssm_pkg::ssm_idx_t s, input ssm_pkg::ssm_mask_t d, input logic [4:0] f);
    u_ssm_stage_model.send(s, d, 8'h01, f, od, oq, os, om, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
  endtask

  // mirror queue 6 lands as bit 6 on top of the incoming queue bit 0
  task automatic mir(input ssm_pkg::ssm_idx_t s, input ssm_pkg::ssm_mask_t d, input logic [4:0] f,
                     input ssm_pkg::ssm_mask_t ed, input logic em);
    frm(s, d, f);
    `CHK(od, ed)
    `CHK(om, em)
    `CHK(oq, em ? 8'h41 : 8'h01)
  endtask

  task automatic pulse(input logic mv, input ssm_pkg::ssm_idx_t ix, input ssm_pkg::ssm_evt_t ev,
                       input logic ld);
    @(posedge pclk);
    move_valid <= mv;
    move_destination_index <= ix;
    event_pulse <= ev;
    learn_discard_pulse <= ld;
    @(posedge pclk);
    {move_valid, move_destination_index, event_pulse, learn_discard_pulse} <= '0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {move_valid, move_destination_index, event_pulse, learn_discard_pulse} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_irq(1'b0);
    for (int i = 0; i < 6; i++)
      rd(ra[i], 32'h0000_0000);
    `CHK(rerr, 1'b0)
    rd(8'h3C, 32'h0000_0000);
    `CHK(rerr, 1'b1)
    rd(8'h01, 32'h0000_0000);
    `CHK(rerr, 1'b1)
    // sampler: rate zero, rx only, tx only on a foreign source
    apb(1'b1, `SSM_OFF_QUEUE_CFG, 32'h0000_0063);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, `SSM_OFF_SAMPLE_CFG0, scfg[c]);
      nsmp = 0;
      repeat (8)
      begin
        frm(ssrc[c], sdst[c], 5'h00);
        nsmp += (os === 1'b1);
        `CHK(oq, os ? 8'h09 : 8'h01)
        `CHK(od, sdst[c] | (os ? 5'h10 : 5'h00))
      end
      `CHK(nsmp > 0, sany[c])
    end
    apb(1'b1, `SSM_OFF_SAMPLE_CFG0, 32'h0000_0000);
    // mirror probes, one at a time; flags are learn, learn_ena, flag_a, hit, request
    apb(1'b1, `SSM_OFF_MIR_DESTINATION_SET, 32'h0000_0012);
    apb(1'b1, `SSM_OFF_EGR_MIR, 32'h0000_0004);
    apb(1'b1, `SSM_OFF_INGR_MIR, 32'h0000_0008);
    apb(1'b1, `SSM_OFF_GEN_CTRL, 32'h0000_0003);
    apb(1'b1, `SSM_OFF_ADV_LEARN, 32'h0000_0008);
    mir(3'h0, 5'h01, 5'b00000, 5'h01, 1'b0);
    mir(3'h0, 5'h01, 5'b10000, 5'h13, 1'b1);
    mir(3'h0, 5'h01, 5'b11000, 5'h1B, 1'b1);
    mir(3'h0, 5'h10, 5'b00000, 5'h12, 1'b1);
    mir(3'h3, 5'h01, 5'b00000, 5'h13, 1'b1);
    mir(3'h0, 5'h04, 5'b00000, 5'h16, 1'b1);
    mir(3'h0, 5'h01, 5'b00100, 5'h13, 1'b1);
    mir(3'h0, 5'h01, 5'b00011, 5'h13, 1'b1);
    mir(3'h0, 5'h01, 5'b00010, 5'h01, 1'b0);
    mir(3'h4, 5'h10, 5'b00000, 5'h02, 1'b1);
    // monitor: moves, events, interrupt mask and clear, discard counter
    apb(1'b1, `SSM_OFF_IRQ_ENABLE, 32'h0000_0004);
    pulse(1'b1, 3'h2, 4'h0, 1'b0);
    rd(`SSM_OFF_MOVE_MASK, 32'h0000_0004);
    chk_irq(1'b1);
    pulse(1'b1, 3'h5, 4'h0, 1'b0);
    pulse(1'b0, 3'h0, 4'hA, 1'b0);
    repeat (3) @(posedge pclk);
    rd(`SSM_OFF_IRQ_STATUS, 32'h0000_0144);
    apb(1'b1, `SSM_OFF_IRQ_CLEAR, 32'h0000_0004);
    rd(`SSM_OFF_IRQ_STATUS, 32'h0000_0140);
    chk_irq(1'b0);
    apb(1'b1, `SSM_OFF_IRQ_ENABLE, 32'h0000_0100);
    chk_irq(1'b1);
    rd(`SSM_OFF_IRQ_CLEAR, 32'h0000_0000);
    apb(1'b1, `SSM_OFF_LEARN_DISC, 32'h0000_FFFF);
    repeat (3) pulse(1'b0, 3'h0, 4'h0, 1'b1);
    rd(`SSM_OFF_LEARN_DISC, 32'h0000_0003);
    print_verdict();
  end
endmodule
